// ### design/ast_pkg.sv
// Constants and types shared by the asynchronous serial transceiver
// Function
// - Mode register picks 7/8 data bits, parity enable, one/two stops, prescale.
// - Clock select: internal rate, optional bit clock out, or external 16x.
// - Line idles high; each character starts with a falling edge.
// - Frame: low start, data LSB first, optional parity, high stop bits.
// - Receiver syncs on start edge, samples at count 8 of 16 per bit.
// - Clock out runs at bit rate, rising at centre of each bit; the code pulses it only while a character is shifted out.
// - Transmit enable sends one idle frame of ones before data.
// - Holding-to-shifter move sets empty flag and requests transmit interrupt.
// - Line held at one while enabled and holding register empty.
// - Receive enable arms start-bit detection.
// - Frame end moves data to holding; bit 7 cleared for 7-bit.
// - Full flag clears by status read then writing zero.
// - Stop bit received as zero raises framing error.
// - Parity mismatch against odd/even select raises parity error.
// - Frame completing with full flag set raises overrun, data dropped.
// - Errors leave full flag unset and request receive-error interrupt.
// - Framing or parity error still transfers the received data.
// - Several errors in one frame set all their flags together.
// - Error flags clear by status read then writing zero.
// - Bit rate is clock over 64 times 4^n times divider plus one.
package ast_pkg;
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_RATE = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [7:0] ADDR_TXD = 8'h10;
  localparam logic [7:0] ADDR_RXD = 8'h14;
  // Mode register bits
  localparam int MODE_SYNC = 7;
  localparam int MODE_SEVEN = 6;
  localparam int MODE_PAR = 5;
  localparam int MODE_ODD = 4;
  localparam int MODE_STOP2 = 3;
  // Control register bits
  localparam int CTRL_TIE = 7;
  localparam int CTRL_RIE = 6;
  localparam int CTRL_TE = 5;
  localparam int CTRL_RE = 4;
  localparam int CTRL_EXT_CLOCK_SELECT = 1;
  localparam int CTRL_CLOCK_OUT_ENABLE = 0;
  // Status register bits
  localparam int STAT_TDE = 7;
  localparam int STAT_RDF = 6;
  localparam int STAT_OVR = 5;
  localparam int STAT_FRM = 4;
  localparam int STAT_PER = 3;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_RATE = 8'hFF;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_STAT = 8'h80;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    TX_IDLE = 4'h1, TX_WAKE = 4'h2, TX_SEND = 4'h4, TX_OFF = 4'h8
  } ast_tx_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'h1, RX_SHIFT = 3'h2, RX_OFF = 3'h4
  } ast_rx_t;
endpackage : ast_pkg

// ### design/ast_rate_gen.sv
// Bit-rate generator: prescaler, divider and sixteen-times tick
`timescale 1ns/1ps
module ast_rate_gen (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] prescale,
  input wire logic [7:0] divider,
  input wire logic extSel,
  input wire logic extClk,
  output logic tick
);
  import ast_pkg::*;
  typedef struct packed {
    logic [5:0] pre;
    logic [7:0] div;
    logic [1:0] quad;
    logic extOld;
    logic tick;
  } ast_rg_t;
  ast_rg_t s_q, s_d;
  logic preDone;
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    s_d.extOld = extClk;
    case (prescale)
      2'h0: preDone = 1'b1;
      2'h1: preDone = s_q.pre[1:0] == 2'h3;
      2'h2: preDone = s_q.pre[3:0] == 4'hF;
      default: preDone = s_q.pre == 6'h3F;
    endcase
    if (extSel) begin
      s_d.tick = extClk & ~s_q.extOld;
    end else begin
      // Clock over 4^n over (N+1) over 4 gives 16x bit rate, 64 per bit
      s_d.pre = preDone ? 6'h00 : s_q.pre + 6'h01;
      if (preDone) begin
        if (s_q.div >= divider) begin
          s_d.div = 8'h00;
          s_d.quad = s_q.quad + 2'h1;
          s_d.tick = s_q.quad == 2'h3;
        end else begin
          s_d.div = s_q.div + 8'h01;
        end
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign tick = s_q.tick;
endmodule : ast_rate_gen

// ### design/ast_serial_unit.sv
// Asynchronous serial transceiver with AXI4-Lite register access
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module ast_serial_unit (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rxLine,
  output logic txLine,
  output logic txLineOe,
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe,
  output logic txEmptyIrq,
  output logic rxFullIrq,
  output logic rxErrorIrq
);
  import ast_pkg::*;

  function automatic logic isReg(input logic [7:0] a);
    isReg = a == ADDR_MODE || a == ADDR_RATE || a == ADDR_CTRL ||
      a == ADDR_STAT || a == ADDR_TXD || a == ADDR_RXD;
  endfunction : isReg

  // Received character: stop bit at the top of the shifter, parity below it
  function automatic logic [7:0] rxPick(input logic [9:0] sh,
                                        input logic sev,
                                        input logic par);
    case ({sev, par})
      2'h0: rxPick = sh[8:1];
      2'h1: rxPick = sh[7:0];
      2'h2: rxPick = {1'b0, sh[8:2]};
      default: rxPick = {1'b0, sh[7:1]};
    endcase
  endfunction : rxPick

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] rate;
    logic [7:0] ctrl;
    logic tde;
    logic rdf;
    logic ovr;
    logic frm;
    logic per;
    logic [4:0] seen;
    logic [7:0] txHold;
    logic [7:0] rxHold;
    logic awHave;
    logic [7:0] awAddr;
    logic wHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    ast_tx_t txSt;
    logic [11:0] txSh;
    logic [3:0] txCnt;
    logic [3:0] txOvs;
    logic txLine;
    logic txOe;
    logic sck;
    logic sckOe;
    ast_rx_t rxSt;
    logic [9:0] rxSh;
    logic [3:0] rxCnt;
    logic [3:0] rxLen;
    logic [3:0] rxOvs;
    logic rxOld;
    logic txIrq;
    logic rxIrq;
    logic erIrq;
  } ast_st_t;

  ast_st_t s_q, s_d;
  logic tick;
  logic seven, parEn, odd, stop2, te, re, ext;
  logic [3:0] dataBits, frameBits;
  logic [7:0] stat;
  logic wrGo, rdGo;
  logic [7:0] wb;
  logic [7:0] rxData;
  logic pBit, rxPar, stopOk, parBad, overrun;

  ast_rate_gen u_rate (
    .clk(clk),
    .rst(rst),
    .prescale(s_q.mode[1:0]),
    .divider(s_q.rate),
    .extSel(ext),
    .extClk(sckIn),
    .tick(tick)
  );

  always_comb begin
    s_d = s_q;
    seven = s_q.mode[MODE_SEVEN];
    parEn = s_q.mode[MODE_PAR];
    odd = s_q.mode[MODE_ODD];
    stop2 = s_q.mode[MODE_STOP2];
    te = s_q.ctrl[CTRL_TE];
    re = s_q.ctrl[CTRL_RE];
    ext = s_q.ctrl[CTRL_EXT_CLOCK_SELECT];
    dataBits = seven ? 4'h7 : 4'h8;
    // Start, data, parity and stop bits
    frameBits = 4'h1 + dataBits + {3'h0, parEn} + (stop2 ? 4'h2 : 4'h1);
    stat = {s_q.tde, s_q.rdf, s_q.ovr, s_q.frm, s_q.per, 3'h0};
    wb = s_q.wData[7:0];
    wrGo = s_q.awHave && s_q.wHave && !s_q.bValid;
    rdGo = s_axi_arvalid && !s_q.rValid;
    rxData = 8'h00;
    pBit = 1'b0;
    rxPar = 1'b0;
    stopOk = 1'b0;
    parBad = 1'b0;
    overrun = 1'b0;
    s_d.txIrq = 1'b0;
    s_d.rxIrq = 1'b0;
    s_d.erIrq = 1'b0;

    // Write channel capture
    if (s_axi_awvalid && !s_q.awHave) begin
      s_d.awHave = 1'b1;
      s_d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.wHave) begin
      s_d.wHave = 1'b1;
      s_d.wData = s_axi_wdata;
      s_d.wStrb = s_axi_wstrb;
    end
    if (s_q.bValid && s_axi_bready) begin
      s_d.bValid = 1'b0;
    end
    if (s_q.rValid && s_axi_rready) begin
      s_d.rValid = 1'b0;
    end

    // Read; status read arms the flags currently at one for clearing
    if (rdGo) begin
      s_d.rValid = 1'b1;
      s_d.rResp = isReg(s_axi_araddr) ? AXI_OKAY : AXI_SLVERR;
      case (s_axi_araddr)
        ADDR_MODE: s_d.rData = {24'h0, s_q.mode};
        ADDR_RATE: s_d.rData = {24'h0, s_q.rate};
        ADDR_CTRL: s_d.rData = {24'h0, s_q.ctrl};
        ADDR_STAT: begin
          s_d.rData = {24'h0, stat};
          s_d.seen = stat[7:3];
        end
        ADDR_TXD: s_d.rData = {24'h0, s_q.txHold};
        ADDR_RXD: s_d.rData = {24'h0, s_q.rxHold};
        default: s_d.rData = 32'h0;
      endcase
    end

    // Register writes; flags clear only by zero after a status read
    if (wrGo) begin
      s_d.awHave = 1'b0;
      s_d.wHave = 1'b0;
      s_d.bValid = 1'b1;
      s_d.bResp = isReg(s_q.awAddr) ? AXI_OKAY : AXI_SLVERR;
      if (s_q.wStrb[0]) begin
        case (s_q.awAddr)
          ADDR_MODE: s_d.mode = wb;
          ADDR_RATE: s_d.rate = wb;
          ADDR_CTRL: s_d.ctrl = wb;
          ADDR_TXD: s_d.txHold = wb;
          ADDR_STAT: begin
            if (!wb[STAT_TDE] && s_q.seen[4]) s_d.tde = 1'b0;
            if (!wb[STAT_RDF] && s_q.seen[3]) s_d.rdf = 1'b0;
            if (!wb[STAT_OVR] && s_q.seen[2]) s_d.ovr = 1'b0;
            if (!wb[STAT_FRM] && s_q.seen[1]) s_d.frm = 1'b0;
            if (!wb[STAT_PER] && s_q.seen[0]) s_d.per = 1'b0;
            s_d.seen = 5'h00;
          end
          default: ;
        endcase
      end
    end

    // Transmitter
    case (s_q.txSt)
      TX_OFF: begin
        s_d.txLine = 1'b1;
        s_d.sckOe = 1'b0;
        if (te) begin
          s_d.txSt = TX_WAKE;
          s_d.txOe = 1'b1;
          s_d.txCnt = 4'h0;
          s_d.txOvs = 4'h0;
        end
      end
      TX_WAKE: begin
        s_d.txLine = 1'b1;
        if (tick) begin
          s_d.txOvs = s_q.txOvs + 4'h1;
          if (s_q.txOvs == OVS_LAST) begin
            s_d.txCnt = s_q.txCnt + 4'h1;
            if (s_q.txCnt + 4'h1 == frameBits) s_d.txSt = TX_IDLE;
          end
        end
      end
      TX_IDLE: begin
        s_d.txLine = 1'b1;
        if (!s_q.tde && tick) begin
          pBit = odd ^ (^(seven ? {1'b0, s_q.txHold[6:0]} : s_q.txHold));
          // Shift order: start, data LSB first, parity, stop ones
          s_d.txSh = {4'hF, s_q.txHold};
          if (seven) s_d.txSh[7] = parEn ? pBit : 1'b1;
          else if (parEn) s_d.txSh[8] = pBit;
          s_d.txLine = 1'b0;
          s_d.tde = 1'b1;
          s_d.txIrq = s_q.ctrl[CTRL_TIE];
          s_d.txCnt = 4'h0;
          // Start bit gets the full sixteen ticks like every other bit
          s_d.txOvs = 4'h0;
          s_d.txSt = TX_SEND;
        end
      end
      TX_SEND: begin
        if (tick) begin
          s_d.txOvs = s_q.txOvs + 4'h1;
          if (s_q.txOvs == OVS_MID) s_d.sck = 1'b1;
          if (s_q.txOvs == OVS_LAST) begin
            s_d.sck = 1'b0;
            s_d.txCnt = s_q.txCnt + 4'h1;
            s_d.txLine = s_q.txSh[0];
            s_d.txSh = {1'b1, s_q.txSh[11:1]};
            if (s_q.txCnt + 4'h1 == frameBits) begin
              s_d.txLine = 1'b1;
              s_d.txSt = TX_IDLE;
            end
          end
        end
      end
      default: s_d.txSt = TX_OFF;
    endcase
    // Clock pin drives only with the internal rate and output enabled
    s_d.sckOe = te && !ext && s_q.ctrl[CTRL_CLOCK_OUT_ENABLE];
    if (!s_d.sckOe) s_d.sck = 1'b0;
    // Clearing transmit enable releases the line at once
    if (!te) begin
      s_d.txSt = TX_OFF;
      s_d.txOe = 1'b0;
      s_d.txLine = 1'b1;
    end

    // Receiver; its flag sets follow the software clears, so a set wins
    s_d.rxOld = rxLine;
    case (s_q.rxSt)
      RX_OFF: if (re) s_d.rxSt = RX_IDLE;
      RX_IDLE: begin
        if (s_q.rxOld && !rxLine) begin
          s_d.rxSt = RX_SHIFT;
          s_d.rxOvs = 4'h0;
          s_d.rxCnt = 4'h0;
          s_d.rxLen = 4'h1 + dataBits + {3'h0, parEn} + 4'h1;
        end
      end
      RX_SHIFT: begin
        if (tick) begin
          s_d.rxOvs = s_q.rxOvs + 4'h1;
          if (s_q.rxOvs == OVS_MID) begin
            s_d.rxCnt = s_q.rxCnt + 4'h1;
            s_d.rxSh = {rxLine, s_q.rxSh[9:1]};
            if (s_q.rxCnt == 4'h0 && rxLine) s_d.rxSt = RX_IDLE;
            if (s_q.rxCnt + 4'h1 == s_q.rxLen) begin
              rxData = rxPick(s_d.rxSh, seven, parEn);
              rxPar = parEn & s_d.rxSh[8];
              stopOk = rxLine;
              parBad = parEn && ((^rxData) ^ rxPar ^ odd);
              overrun = s_q.rdf;
              if (!overrun) s_d.rxHold = rxData;
              if (!stopOk) s_d.frm = 1'b1;
              if (parBad) s_d.per = 1'b1;
              if (overrun) s_d.ovr = 1'b1;
              if (stopOk && !parBad && !overrun) begin
                s_d.rdf = 1'b1;
                s_d.rxIrq = s_q.ctrl[CTRL_RIE];
              end else begin
                s_d.erIrq = s_q.ctrl[CTRL_RIE];
              end
              s_d.rxSt = RX_IDLE;
            end
          end
        end
      end
      default: s_d.rxSt = RX_OFF;
    endcase
    // Clearing receive enable abandons any frame in progress
    if (!re) s_d.rxSt = RX_OFF;
  end

  // Reset leaves the line at mark and the empty flag set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.mode <= RST_MODE;
      s_q.rate <= RST_RATE;
      s_q.ctrl <= RST_CTRL;
      s_q.tde <= RST_STAT[STAT_TDE];
      s_q.txSt <= TX_OFF;
      s_q.rxSt <= RX_OFF;
      s_q.txLine <= 1'b1;
      s_q.rxOld <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = !s_q.awHave;
  assign s_axi_wready = !s_q.wHave;
  assign s_axi_bvalid = s_q.bValid;
  assign s_axi_bresp = s_q.bResp;
  assign s_axi_arready = !s_q.rValid;
  assign s_axi_rvalid = s_q.rValid;
  assign s_axi_rdata = s_q.rData;
  assign s_axi_rresp = s_q.rResp;
  assign txLine = s_q.txLine;
  assign txLineOe = s_q.txOe;
  assign sckOut = s_q.sck;
  assign sckOe = s_q.sckOe;
  assign txEmptyIrq = s_q.txIrq;
  assign rxFullIrq = s_q.rxIrq;
  assign rxErrorIrq = s_q.erIrq;
endmodule : ast_serial_unit

// ### dv/ast_serial_unit_checker.sv
// Port assertions for the asynchronous serial transceiver
`timescale 1ns/1ps
module ast_serial_unit_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic txLine,
  input wire logic txLineOe,
  input wire logic sckOut,
  input wire logic sckOe,
  input wire logic txEmptyIrq,
  input wire logic rxFullIrq,
  input wire logic rxErrorIrq
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  a_idle_mark: assert property (!txLineOe |-> txLine)
    else $error("line low while transmitter off");
  a_start_width: assert property ($fell(txLine) |-> !txLine [*8])
    else $error("start bit too short");
  a_clk_centre: assert property (
    sckOe && $rose(sckOut) |-> $stable(txLine))
    else $error("clock out rises at a bit edge");
  a_err_not_full: assert property (rxErrorIrq |-> !rxFullIrq)
    else $error("full and error requests together");
  a_tx_pulse: assert property (txEmptyIrq |=> !txEmptyIrq)
    else $error("transmit request too long");
  a_write_once: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answered twice");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_once: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answered twice");
endmodule : ast_serial_unit_checker

bind ast_serial_unit ast_serial_unit_checker u_check (
  .clk, .rst, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .txLine, .txLineOe,
  .sckOut, .sckOe, .txEmptyIrq, .rxFullIrq, .rxErrorIrq
);

// ### dv/ast_line_partner.sv
// Remote serial device on the line side of the transceiver
`timescale 1ns/1ps
module ast_line_partner (
  input wire logic clk,
  output logic rxLine,
  input wire logic txLine
);
  int bitClks = 64;
  time tFall;
  initial rxLine = 1'b1;
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rxLine <= f[i];
      repeat (bitClks - 1) @(posedge clk);
    end
    @(posedge clk);
    rxLine <= 1'b1;
  endtask : send
  // Samples each bit at its centre, timed from the start edge
  task automatic recv(input int n, output logic [11:0] f);
    f = 12'hFFF;
    while (txLine !== 1'b0) @(posedge clk);
    tFall = $time;
    repeat (bitClks / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      f[i] = txLine;
      repeat (bitClks) @(posedge clk);
    end
  endtask : recv
endmodule : ast_line_partner

// ### dv/ast_serial_unit_tb.sv
// Self-checking bench for the asynchronous serial transceiver
`timescale 1ns/1ps
module ast_serial_unit_tb;
  import ast_pkg::*;
  logic clk, rst, extOn, rxLine, txLine, txLineOe;
  logic sckIn = 1'b0, sckOld = 1'b0;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, sckOut, sckOe;
  logic txEmptyIrq, rxFullIrq, rxErrorIrq;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [1:0] sckDiv = 2'h0;
  logic [3:0] s_axi_wstrb;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdVal;
  int mismatches, checks_done, txIrqN, fullN, errN, sckN;
  ast_serial_unit dut (
    .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .rxLine, .txLine, .txLineOe, .sckIn,
    .sckOut, .sckOe, .txEmptyIrq, .rxFullIrq, .rxErrorIrq
  );
  ast_line_partner peer (.clk, .rxLine, .txLine);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // External clock rises every four cycles: sixteen per 64-cycle bit
  always @(posedge clk) begin
    sckDiv <= sckDiv + 2'h1;
    sckIn <= extOn & sckDiv[1];
    txIrqN <= txIrqN + int'(txEmptyIrq);
    fullN <= fullN + int'(rxFullIrq);
    errN <= errN + int'(rxErrorIrq);
    sckOld <= sckOut;
    sckN <= sckN + int'(sckOut & ~sckOld);
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdVal = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic rdChk(input logic [7:0] a, exp);
    rd(a);
    chk($sformatf("register %h", a), rdVal, {24'h0, exp});
  endtask : rdChk
  // Enables off, format and rate, one slow bit time, then enables
  task automatic cfg(input logic [7:0] m, r, c);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_MODE, m);
    wr(ADDR_RATE, r);
    repeat (600) @(posedge clk);
    wr(ADDR_CTRL, c);
  endtask : cfg
  function automatic logic [11:0] frm(input logic [7:0] m, d,
                                      output int n);
    int b;
    b = m[MODE_SEVEN] ? 7 : 8;
    frm = 12'hFFF;
    frm[0] = 1'b0;
    for (int i = 0; i < b; i++) frm[1 + i] = d[i];
    n = b + 1;
    if (m[MODE_PAR]) begin
      frm[n] = ^(d & (m[MODE_SEVEN] ? 8'h7F : 8'hFF)) ^ m[MODE_ODD];
      n++;
    end
    n = n + 1 + int'(m[MODE_STOP2]);
  endfunction : frm
  task automatic t_regs;
    rdChk(ADDR_MODE, RST_MODE);
    rdChk(ADDR_RATE, RST_RATE);
    rdChk(ADDR_CTRL, RST_CTRL);
    rdChk(ADDR_STAT, RST_STAT);
    wr(ADDR_RATE, 8'h5A);
    rdChk(ADDR_RATE, 8'h5A);
    wr(8'h18, 8'h01);
    chk("write resp", resp, AXI_SLVERR);
    rdChk(8'h18, 8'h00);
    chk("read resp", resp, AXI_SLVERR);
    $display("test registers done");
  endtask : t_regs
  task automatic t_tx;
    logic [7:0] md [4] = '{8'h00, 8'h28, 8'h70, 8'h48};
    logic [7:0] dt [4] = '{8'hA5, 8'h3C, 8'hD3, 8'h7E};
    logic [11:0] f, got;
    int n, k, s;
    time t0;
    for (int j = 0; j < 4; j++) begin
      f = frm(md[j], dt[j], n);
      cfg(md[j], 8'h00, 8'hA1);
      t0 = $time;
      k = txIrqN;
      s = sckN;
      fork
        peer.recv(n, got);
        begin
          wr(ADDR_TXD, dt[j]);
          rd(ADDR_STAT);
          wr(ADDR_STAT, 8'h00);
        end
      join
      chk("tx frame", got, f);
      chk("idle frame", peer.tFall + 100 - t0 >= n * 640, 1'b1);
      chk("tx request", txIrqN - k, 1);
      chk("clock pin out", sckOe, 1'b1);
      chk("clock pulses", sckN - s, n);
      chk("tx drive", txLineOe, 1'b1);
      repeat (200) @(posedge clk);
      chk("tx mark", txLine, 1'b1);
    end
    $display("test transmit done");
  endtask : t_tx
  task automatic rxOne(input logic [7:0] m, r, c, d, input logic [1:0] bad,
                       input logic [7:0] st, rx);
    logic [11:0] f;
    int n, a, b;
    f = frm(m, d, n);
    if (bad[0]) f[n - 2] = ~f[n - 2];
    if (bad[1]) f[n - 1] = 1'b0;
    cfg(m, r, c);
    a = fullN;
    b = errN;
    peer.send(f, n);
    repeat (20) @(posedge clk);
    rdChk(ADDR_STAT, st);
    rdChk(ADDR_RXD, rx);
    chk("full irq", fullN - a, int'(st[5:3] == 3'h0));
    chk("error irq", errN - b, int'(st[5:3] != 3'h0));
    wr(ADDR_STAT, 8'h80);
    rdChk(ADDR_STAT, 8'h80);
  endtask : rxOne
  task automatic t_rx;
    rxOne(8'h00, 8'h00, 8'h50, 8'hA5, 2'h0, 8'hC0, 8'hA5);
    rxOne(8'h30, 8'h00, 8'h50, 8'h5A, 2'h0, 8'hC0, 8'h5A);
    rxOne(8'h48, 8'h00, 8'h50, 8'hFF, 2'h0, 8'hC0, 8'h7F);
    rxOne(8'h20, 8'h00, 8'h50, 8'h33, 2'h1, 8'h88, 8'h33);
    rxOne(8'h00, 8'h00, 8'h50, 8'h0F, 2'h2, 8'h90, 8'h0F);
    rxOne(8'h60, 8'h00, 8'h50, 8'h11, 2'h3, 8'h98, 8'h11);
    peer.bitClks = 512;
    rxOne(8'h01, 8'h01, 8'h50, 8'h96, 2'h0, 8'hC0, 8'h96);
    peer.bitClks = 64;
    extOn <= 1'b1;
    rxOne(8'h01, 8'h01, 8'h52, 8'h69, 2'h0, 8'hC0, 8'h69);
    chk("clock pin in", sckOe, 1'b0);
    chk("tx released", txLineOe, 1'b0);
    extOn <= 1'b0;
    $display("test receive done");
  endtask : t_rx
  task automatic t_over;
    logic [11:0] f;
    int n;
    cfg(8'h00, 8'h00, 8'h50);
    f = frm(8'h00, 8'h3C, n);
    peer.send(f, n);
    f = frm(8'h00, 8'hC3, n);
    peer.send(f, n);
    repeat (20) @(posedge clk);
    rdChk(ADDR_STAT, 8'hE0);
    rdChk(ADDR_RXD, 8'h3C);
    wr(ADDR_STAT, 8'h80);
    rdChk(ADDR_STAT, 8'h80);
    $display("test overrun done");
  endtask : t_over
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  initial begin
    rst = 1'b1;
    {extOn, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_tx;
    t_rx;
    t_over;
    results;
  end
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    results;
  end
endmodule : ast_serial_unit_tb
